//--- jtb_cfg.svh
/*
 * constants of the boundary scan test port: chain cell positions,
 * instruction codes, reset values and controller timing.
 * assumes it is included by bare name after the package is compiled.
 */
// How it works
// - sixteen-state controller, tms steered, tck clocked
// - reset state: test logic off, identity instruction
// - run-test/idle holds while tms low
// - capture-dr loads chain from input pins, core values and enables
// - shift-dr moves selected register toward tdo
// - update-dr copies chain into output latches
// - capture-ir loads fixed pattern
// - shift-ir moves instruction register one bit
// - update-ir makes shifted instruction current
// - pause states hold shift registers unchanged
// - exit states only pass, nothing altered
// - chain data enters least significant first
// - every pin a cell, tristates add control
// - chain starts channel 3 then channel 2
// - then clocks, mode, interrupt, ack, strobes, address
// - rx float control: 0 drives, 1 floats
// - ack float control: 0 drives, 1 floats
`ifndef JTB_CFG_SVH
`define JTB_CFG_SVH

// -----------------------------------------------------------------
// chain layout
// -----------------------------------------------------------------
`define JTB_CHAIN_LEN               27
`define JTB_POS_LOSS_OF_SIGNAL_CH3  0
`define JTB_POS_RX_NEGATIVE_CH3     1
`define JTB_POS_FLOAT3              2
`define JTB_POS_RX_POSITIVE_CH3     3
`define JTB_POS_RX_CLOCK_CH3        4
`define JTB_POS_TX_NEGATIVE_CH3     5
`define JTB_POS_TX_POSITIVE_CH3     6
`define JTB_POS_TX_CLOCK_CH3        7
`define JTB_POS_LOSS_OF_SIGNAL_CH2  8
`define JTB_POS_RX_NEGATIVE_CH2     9
`define JTB_POS_FLOAT2              10
`define JTB_POS_RX_POSITIVE_CH2     11
`define JTB_POS_RX_CLOCK_CH2        12
`define JTB_POS_TX_NEGATIVE_CH2     13
`define JTB_POS_TX_POSITIVE_CH2     14
`define JTB_POS_TX_CLOCK_CH2        15
`define JTB_POS_MCLK                16
`define JTB_POS_MODE                17
`define JTB_POS_INTR                18
`define JTB_POS_ACKFLT              19
`define JTB_POS_ACK                 20
`define JTB_POS_ALE                 21
`define JTB_POS_OE                  22
`define JTB_POS_CLOCK_EDGE_SELECT   23
`define JTB_POS_A0                  24

// -----------------------------------------------------------------
// pin groups and instructions
// -----------------------------------------------------------------
`define JTB_NUM_OUT        10
`define JTB_NUM_IN         14
`define JTB_IR_LEN         3
`define JTB_IR_EXTEST      3'h0
`define JTB_IR_SAMPLE      3'h1
`define JTB_IR_IDENT       3'h2
`define JTB_IR_BYPASS      3'h7
`define JTB_IR_CAPTURE     3'h1
`define JTB_ID_VALUE       32'h0a5a5001 // arbitrary identity value
`define JTB_FLOAT_RST      1'h1
`define JTB_RESET_TMS_CYC  5

`endif

//--- jtb_pkg.sv
/*
 * types of the boundary scan test port: controller states.
 * assumes nothing beyond a systemverilog compiler.
 */
package jtb_pkg;

    // one-hot controller states
    typedef enum logic [15:0]
    {
        st_reset   = 16'h0001,
        st_idle    = 16'h0002,
        st_sel_dr  = 16'h0004,
        st_cap_dr  = 16'h0008,
        st_sh_dr   = 16'h0010,
        st_ex1_dr  = 16'h0020,
        st_pau_dr  = 16'h0040,
        st_ex2_dr  = 16'h0080,
        st_upd_dr  = 16'h0100,
        st_sel_ir  = 16'h0200,
        st_cap_ir  = 16'h0400,
        st_sh_ir   = 16'h0800,
        st_ex1_ir  = 16'h1000,
        st_pau_ir  = 16'h2000,
        st_ex2_ir  = 16'h4000,
        st_upd_ir  = 16'h8000
    } jtb_state_t;

endpackage

//--- jtb_sync.sv
/*
 * two-flop level synchroniser, one per bit.
 * assumes every bit is an independent slow level.
 */
`timescale 1ns/100ps
`default_nettype none

module jtb_sync
#(
    parameter int W = 1
)
(
    input  wire logic         clk_in,   // destination clock
    input  wire logic         nrst_in,  // async reset, low
    input  wire logic [W-1:0] d_in,     // foreign level
    output logic      [W-1:0] q_out     // synchronised level
);

    logic [W-1:0] meta;

    // first stage is read only by the second
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            meta  <= '0;
            q_out <= '0;
        end
        else
        begin
            meta  <= d_in;
            q_out <= meta;
        end
    end

endmodule
`default_nettype wire

//--- jtb_tap_ctl.sv
/*
 * sixteen-state test access controller.
 * assumes tms is a level of the tck domain.
 */
`timescale 1ns/100ps
`default_nettype none

module jtb_tap_ctl
(
    input  wire logic        tck_in,   // test clock
    input  wire logic        nrst_in,  // async reset, low
    input  wire logic        tms_in,   // mode select
    output jtb_pkg::jtb_state_t state_out // controller state
);

    jtb_pkg::jtb_state_t next_state;

    // standard controller graph
    always_comb
    begin
        case (state_out)
            jtb_pkg::st_reset:  next_state = tms_in ? jtb_pkg::st_reset
                                                    : jtb_pkg::st_idle;
            jtb_pkg::st_idle:   next_state = tms_in ? jtb_pkg::st_sel_dr
                                                    : jtb_pkg::st_idle;
            jtb_pkg::st_sel_dr: next_state = tms_in ? jtb_pkg::st_sel_ir
                                                    : jtb_pkg::st_cap_dr;
            jtb_pkg::st_cap_dr: next_state = tms_in ? jtb_pkg::st_ex1_dr
                                                    : jtb_pkg::st_sh_dr;
            jtb_pkg::st_sh_dr:  next_state = tms_in ? jtb_pkg::st_ex1_dr
                                                    : jtb_pkg::st_sh_dr;
            jtb_pkg::st_ex1_dr: next_state = tms_in ? jtb_pkg::st_upd_dr
                                                    : jtb_pkg::st_pau_dr;
            jtb_pkg::st_pau_dr: next_state = tms_in ? jtb_pkg::st_ex2_dr
                                                    : jtb_pkg::st_pau_dr;
            jtb_pkg::st_ex2_dr: next_state = tms_in ? jtb_pkg::st_upd_dr
                                                    : jtb_pkg::st_sh_dr;
            jtb_pkg::st_upd_dr: next_state = tms_in ? jtb_pkg::st_sel_dr
                                                    : jtb_pkg::st_idle;
            jtb_pkg::st_sel_ir: next_state = tms_in ? jtb_pkg::st_reset
                                                    : jtb_pkg::st_cap_ir;
            jtb_pkg::st_cap_ir: next_state = tms_in ? jtb_pkg::st_ex1_ir
                                                    : jtb_pkg::st_sh_ir;
            jtb_pkg::st_sh_ir:  next_state = tms_in ? jtb_pkg::st_ex1_ir
                                                    : jtb_pkg::st_sh_ir;
            jtb_pkg::st_ex1_ir: next_state = tms_in ? jtb_pkg::st_upd_ir
                                                    : jtb_pkg::st_pau_ir;
            jtb_pkg::st_pau_ir: next_state = tms_in ? jtb_pkg::st_ex2_ir
                                                    : jtb_pkg::st_pau_ir;
            jtb_pkg::st_ex2_ir: next_state = tms_in ? jtb_pkg::st_upd_ir
                                                    : jtb_pkg::st_sh_ir;
            jtb_pkg::st_upd_ir: next_state = tms_in ? jtb_pkg::st_sel_dr
                                                    : jtb_pkg::st_idle;
            default:            next_state = jtb_pkg::st_reset;
        endcase
    end

    // state register on rising tck
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
            state_out <= jtb_pkg::st_reset;
        else
            state_out <= next_state;
    end

endmodule
`default_nettype wire

//--- jtb_tap.sv
/*
 * boundary scan test port top: controller, instruction register,
 * identity and bypass registers, boundary_scan_chain, pin muxing.
 * assumes pins are foreign levels, core signals run on clk_in,
 * and tck is a free clock of the tester, unrelated to clk_in.
 */
`timescale 1ns/100ps
`default_nettype none
`include "jtb_cfg.svh"

module jtb_tap
#(
    parameter int          IR_LEN = `JTB_IR_LEN,
    parameter logic [31:0] ID_VAL = `JTB_ID_VALUE  // arbitrary value
)
(
    input  wire logic        clk_in,            // system clock
    input  wire logic        nrst_in,           // async reset, low
    input  wire logic        tck_in,            // test clock
    input  wire logic        tms_in,            // test mode select
    input  wire logic        tdi_in,            // test data in
    output logic             tdo_out,           // test data out
    output logic             tdo_oe_out,        // tdo driven
    input  wire logic [`JTB_NUM_OUT-1:0] core_val_in,  // core pin values
    input  wire logic [1:0]  core_rx_en_in,     // core rx drive, ch3 ch2
    input  wire logic        core_ack_en_in,    // core ack drive
    input  wire logic [`JTB_NUM_IN-1:0]  pin_in,       // input pins
    output logic [`JTB_NUM_OUT-1:0]      pin_val_out,  // output pins
    output logic [1:0]       pin_rx_oe_out,     // rx pins driven
    output logic             pin_ack_oe_out,    // ack pin driven
    output logic [`JTB_NUM_IN-1:0]       core_pin_out, // pins to core
    output logic             test_active_out    // pins under test
);

    // ---------------------------------------------------------------
    // checks and functions
    // ---------------------------------------------------------------
    if (IR_LEN < 2 || IR_LEN > `JTB_IR_LEN)
    begin
        $error("jtb_tap: instruction length not served");
    end

    localparam int CL = `JTB_CHAIN_LEN;

    // output-cell positions in core value order
    function automatic int out_pos(input int i);
        case (i)
            0:       out_pos = `JTB_POS_LOSS_OF_SIGNAL_CH3;
            1:       out_pos = `JTB_POS_RX_NEGATIVE_CH3;
            2:       out_pos = `JTB_POS_RX_POSITIVE_CH3;
            3:       out_pos = `JTB_POS_RX_CLOCK_CH3;
            4:       out_pos = `JTB_POS_LOSS_OF_SIGNAL_CH2;
            5:       out_pos = `JTB_POS_RX_NEGATIVE_CH2;
            6:       out_pos = `JTB_POS_RX_POSITIVE_CH2;
            7:       out_pos = `JTB_POS_RX_CLOCK_CH2;
            8:       out_pos = `JTB_POS_INTR;
            default: out_pos = `JTB_POS_ACK;
        endcase
    endfunction

    // input-cell positions in pin order
    function automatic int in_pos(input int i);
        case (i)
            0:       in_pos = `JTB_POS_TX_NEGATIVE_CH3;
            1:       in_pos = `JTB_POS_TX_POSITIVE_CH3;
            2:       in_pos = `JTB_POS_TX_CLOCK_CH3;
            3:       in_pos = `JTB_POS_TX_NEGATIVE_CH2;
            4:       in_pos = `JTB_POS_TX_POSITIVE_CH2;
            5:       in_pos = `JTB_POS_TX_CLOCK_CH2;
            6:       in_pos = `JTB_POS_MCLK;
            7:       in_pos = `JTB_POS_MODE;
            8:       in_pos = `JTB_POS_ALE;
            9:       in_pos = `JTB_POS_OE;
            10:      in_pos = `JTB_POS_CLOCK_EDGE_SELECT;
            default: in_pos = `JTB_POS_A0 + i - 11;
        endcase
    endfunction

    // chain image of pins, core values and enables
    function automatic logic [CL-1:0] pack_chain(
        input logic [`JTB_NUM_OUT-1:0] vals,
        input logic [`JTB_NUM_IN-1:0]  pins,
        input logic [1:0]              rx_en,
        input logic                    ack_en);
        logic [CL-1:0] c;
        c = '0;
        for (int i = 0; i < `JTB_NUM_OUT; i++)
            c[out_pos(i)] = vals[i];
        for (int i = 0; i < `JTB_NUM_IN; i++)
            c[in_pos(i)] = pins[i];
        c[`JTB_POS_FLOAT3] = ~rx_en[0];
        c[`JTB_POS_FLOAT2] = ~rx_en[1];
        c[`JTB_POS_ACKFLT] = ~ack_en;
        pack_chain = c;
    endfunction

    // output-cell values out of a chain image
    function automatic logic [`JTB_NUM_OUT-1:0] chain_vals(
        input logic [CL-1:0] c);
        logic [`JTB_NUM_OUT-1:0] v;
        v = '0;
        for (int i = 0; i < `JTB_NUM_OUT; i++)
            v[i] = c[out_pos(i)];
        chain_vals = v;
    endfunction

    // ---------------------------------------------------------------
    // test clock domain
    // ---------------------------------------------------------------
    jtb_pkg::jtb_state_t           state;
    logic [IR_LEN-1:0]             ir_shift;
    logic [IR_LEN-1:0]             ir;
    logic [CL-1:0]                 chain_shift;
    logic [CL-1:0]                 chain_upd;
    logic [31:0]                   id_shift;
    logic                          bypass;
    logic                          ext_mode;
    logic [`JTB_NUM_IN-1:0]        pin_tck;
    logic [`JTB_NUM_OUT+2:0]       core_tck;
    logic                          sel_chain;
    logic                          sel_id;

    jtb_tap_ctl u_ctl
    (
        .tck_in    (tck_in),
        .nrst_in   (nrst_in),
        .tms_in    (tms_in),
        .state_out (state)
    );

    // pins and core values into the test domain
    jtb_sync #(.W(`JTB_NUM_IN + `JTB_NUM_OUT + 3)) u_sync_tck
    (
        .clk_in  (tck_in),
        .nrst_in (nrst_in),
        .d_in    ({core_ack_en_in, core_rx_en_in, core_val_in, pin_in}),
        .q_out   ({core_tck, pin_tck})
    );

    // data register selection
    assign sel_chain = (ir == IR_LEN'(`JTB_IR_EXTEST)) ||
                       (ir == IR_LEN'(`JTB_IR_SAMPLE));
    assign sel_id    = (ir == IR_LEN'(`JTB_IR_IDENT));

    // instruction shift register
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ir_shift <= IR_LEN'(`JTB_IR_CAPTURE);
        else if (state == jtb_pkg::st_cap_ir)
            ir_shift <= IR_LEN'(`JTB_IR_CAPTURE);
        else if (state == jtb_pkg::st_sh_ir)
            ir_shift <= {tdi_in, ir_shift[IR_LEN-1:1]};
    end

    // current instruction
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ir <= IR_LEN'(`JTB_IR_IDENT);
        else if (state == jtb_pkg::st_reset)
            ir <= IR_LEN'(`JTB_IR_IDENT);
        else if (state == jtb_pkg::st_upd_ir)
            ir <= ir_shift;
    end

    // boundary scan chain shift stage, held in pause and exit
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
            chain_shift <= '0;
        else if (sel_chain && state == jtb_pkg::st_cap_dr)
            chain_shift <= pack_chain(core_tck[`JTB_NUM_OUT-1:0],
                                      pin_tck,
                                      core_tck[`JTB_NUM_OUT+1 -: 2],
                                      core_tck[`JTB_NUM_OUT+2]);
        else if (sel_chain && state == jtb_pkg::st_sh_dr)
            chain_shift <= {tdi_in, chain_shift[CL-1:1]};
    end

    // chain parallel output latches
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            chain_upd                  <= '0;
            chain_upd[`JTB_POS_FLOAT3] <= `JTB_FLOAT_RST;
            chain_upd[`JTB_POS_FLOAT2] <= `JTB_FLOAT_RST;
            chain_upd[`JTB_POS_ACKFLT] <= `JTB_FLOAT_RST;
        end
        else if (sel_chain && state == jtb_pkg::st_upd_dr)
            chain_upd <= chain_shift;
    end

    // identity and bypass registers
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            id_shift <= '0;
            bypass   <= 1'h0;
        end
        else if (state == jtb_pkg::st_cap_dr)
        begin
            id_shift <= ID_VAL;
            bypass   <= 1'h0;
        end
        else if (state == jtb_pkg::st_sh_dr)
        begin
            id_shift <= {tdi_in, id_shift[31:1]};
            bypass   <= tdi_in;
        end
    end

    // pins under test only with extest outside reset state
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
            ext_mode <= 1'h0;
        else
            ext_mode <= (ir == IR_LEN'(`JTB_IR_EXTEST)) &&
                        (state != jtb_pkg::st_reset);
    end

    // serial output on falling tck, floating outside shift
    always_ff @(negedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            tdo_out    <= 1'h0;
            tdo_oe_out <= 1'h0;
        end
        else
        begin
            tdo_oe_out <= (state == jtb_pkg::st_sh_dr) ||
                          (state == jtb_pkg::st_sh_ir);
            if (state == jtb_pkg::st_sh_ir)
                tdo_out <= ir_shift[0];
            else if (state == jtb_pkg::st_sh_dr)
                tdo_out <= sel_chain ? chain_shift[0] :
                           sel_id    ? id_shift[0]    : bypass;
            else
                tdo_out <= 1'h0;
        end
    end

    // ---------------------------------------------------------------
    // system clock domain
    // ---------------------------------------------------------------
    logic                          ext_sys;
    logic [CL-1:0]                 upd_sys;
    logic [`JTB_NUM_IN-1:0]        pin_sys;

    // latches and mode into the system domain, bit by bit levels
    jtb_sync #(.W(CL + 1)) u_sync_upd
    (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    ({ext_mode, chain_upd}),
        .q_out   ({ext_sys, upd_sys})
    );

    // input pins to the core
    jtb_sync #(.W(`JTB_NUM_IN)) u_sync_pin
    (
        .clk_in  (clk_in),
        .nrst_in (nrst_in),
        .d_in    (pin_in),
        .q_out   (pin_sys)
    );

    // pin drive: core in normal mode, latches under extest
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            pin_val_out     <= '0;
            pin_rx_oe_out   <= 2'h0;
            pin_ack_oe_out  <= 1'h0;
            test_active_out <= 1'h0;
        end
        else if (ext_sys)
        begin
            pin_val_out      <= chain_vals(upd_sys);
            pin_rx_oe_out[0] <= ~upd_sys[`JTB_POS_FLOAT3];
            pin_rx_oe_out[1] <= ~upd_sys[`JTB_POS_FLOAT2];
            pin_ack_oe_out   <= ~upd_sys[`JTB_POS_ACKFLT];
            test_active_out  <= 1'h1;
        end
        else
        begin
            pin_val_out     <= core_val_in;
            pin_rx_oe_out   <= core_rx_en_in;
            pin_ack_oe_out  <= core_ack_en_in;
            test_active_out <= 1'h0;
        end
    end

    // core always sees the pins
    always_ff @(posedge clk_in or negedge nrst_in)
    begin
        if (!nrst_in)
            core_pin_out <= '0;
        else
            core_pin_out <= pin_sys;
    end

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    logic [2:0] tms_high_cnt;

    // counts consecutive high tms samples
    always_ff @(posedge tck_in or negedge nrst_in)
    begin
        if (!nrst_in)
            tms_high_cnt <= 3'h0;
        else if (!tms_in)
            tms_high_cnt <= 3'h0;
        else if (tms_high_cnt != 3'h7)
            tms_high_cnt <= tms_high_cnt + 3'h1;
    end

    a_tms_reset_five: assert property (@(posedge tck_in) disable iff (!nrst_in)
        tms_high_cnt >= 3'(`JTB_RESET_TMS_CYC) |-> state == jtb_pkg::st_reset)
        else $error("five high tms did not reach reset");
    a_idle_dwell: assert property (@(posedge tck_in) disable iff (!nrst_in)
        state == jtb_pkg::st_idle && !tms_in |=> state == jtb_pkg::st_idle)
        else $error("left idle with tms low");
    a_reset_ident_ir: assert property (@(posedge tck_in) disable iff (!nrst_in)
        state == jtb_pkg::st_reset |=> ir == IR_LEN'(`JTB_IR_IDENT) && !ext_mode)
        else $error("reset state lacks identity instruction");
    a_cap_ir_pattern: assert property (@(posedge tck_in) disable iff (!nrst_in)
        state == jtb_pkg::st_cap_ir |=> ir_shift == IR_LEN'(`JTB_IR_CAPTURE))
        else $error("capture-ir pattern wrong");
    a_shift_ir_move: assert property (@(posedge tck_in) disable iff (!nrst_in)
        state == jtb_pkg::st_sh_ir |=>
        ir_shift[IR_LEN-2:0] == $past(ir_shift[IR_LEN-1:1]))
        else $error("instruction register did not shift");
    a_update_ir_load: assert property (@(posedge tck_in) disable iff (!nrst_in)
        state == jtb_pkg::st_upd_ir |=> ir == $past(ir_shift))
        else $error("update-ir lost instruction");
    a_chain_lsb_first: assert property (@(posedge tck_in) disable iff (!nrst_in)
        sel_chain && state == jtb_pkg::st_sh_dr |=>
        chain_shift[CL-1] == $past(tdi_in) &&
        chain_shift[CL-2:0] == $past(chain_shift[CL-1:1]))
        else $error("chain shift order wrong");
    a_pause_hold: assert property (@(posedge tck_in) disable iff (!nrst_in)
        (state == jtb_pkg::st_pau_dr || state == jtb_pkg::st_ex1_dr ||
         state == jtb_pkg::st_ex2_dr || state == jtb_pkg::st_pau_ir)
        |=> $stable(chain_shift) && $stable(ir_shift))
        else $error("shift register moved while held");
    a_update_dr_load: assert property (@(posedge tck_in) disable iff (!nrst_in)
        sel_chain && state == jtb_pkg::st_upd_dr |=>
        chain_upd == $past(chain_shift))
        else $error("update-dr did not load latches");
    a_tdo_float: assert property (@(negedge tck_in) disable iff (!nrst_in)
        state != jtb_pkg::st_sh_dr && state != jtb_pkg::st_sh_ir
        |=> !tdo_oe_out)
        else $error("tdo driven outside shift");
    a_ack_float: assert property (@(posedge clk_in) disable iff (!nrst_in)
        ext_sys |=> pin_ack_oe_out == !$past(upd_sys[`JTB_POS_ACKFLT]))
        else $error("ack float control wrong");

endmodule
`default_nettype wire

//--- jtb_tester.sv
/*
 * tester model: drives tms and tdi, reads tdo, on the bench's tck.
 * assumes tck runs free and the device samples on rising tck.
 */
`timescale 1ns/100ps
`default_nettype none
module jtb_tester
(
    input  wire logic tck_in,  // test clock
    output logic      tms_out, // mode select
    output logic      tdi_out, // data to device
    input  wire logic tdo_in   // data from device
);
    initial
    begin
        tms_out = 1'h1;
        tdi_out = 1'h0;
    end
    // one controller step, changed after falling tck
    task step(input logic m);
        @(negedge tck_in);
        tms_out <= m;
        tdi_out <= ~tdi_out; // no stale data outside shifts
        @(posedge tck_in);
    endtask
    // force reset, then dwell in idle
    task reset_tap();
        repeat (5) step(1'h1);
        repeat (3) step(1'h0);
    endtask
    // full ir or dr scan from idle back to idle, lsb first,
    // with a pause after bit p when p is from 0 to n - 2
    task scan(input logic ir, input int n, input logic [31:0] d,
              input int p, output logic [31:0] q);
        q = 32'h0;
        step(1'h1);
        if (ir)
        begin
            step(1'h1);
        end
        step(1'h0);
        step(1'h0);
        for (int i = 0; i < n; i++)
        begin
            @(negedge tck_in);
            tdi_out <= d[i];
            tms_out <= (i == n - 1) || (i == p);
            @(posedge tck_in);
            q[i] = tdo_in;
            if (i == p && i != n - 1)
            begin
                step(1'h0);
                step(1'h0);
                step(1'h1);
                step(1'h0);
            end
        end
        step(1'h1);
        step(1'h0);
    endtask
endmodule
`default_nettype wire

//--- jtb_tap_boundary_scan_bench.sv
/*
 * self-checking bench of the test port with a tester model.
 * assumes the design files and jtb_cfg.svh are compiled first.
 */
`timescale 1ns/100ps
`default_nettype none
`include "jtb_cfg.svh"
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin err_count++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module jtb_tap_boundary_scan_bench;
    logic        clk_in = 1'h0, tck = 1'h0, nrst_in = 1'h0;
    logic        tms, tdi, tdo, tdo_oe, ack_en = 1'h0, ack_oe, act;
    logic [9:0]  cv = 10'h0, pv;
    logic [13:0] pin = 14'h0, cp;
    logic [1:0]  rx_en = 2'h0, rx_oe;
    logic [31:0] q, d, r, seed = 32'he22a;
    int          err_count = 0, checked = 0, cyc = 0;
    always #5 clk_in = ~clk_in;
    always #6 tck = ~tck;
    jtb_tap DUT (.clk_in(clk_in), .nrst_in(nrst_in), .tck_in(tck),
        .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
        .core_val_in(cv), .core_rx_en_in(rx_en), .core_ack_en_in(ack_en),
        .pin_in(pin), .pin_val_out(pv), .pin_rx_oe_out(rx_oe),
        .pin_ack_oe_out(ack_oe), .core_pin_out(cp), .test_active_out(act));
    jtb_tester u_tst (.tck_in(tck), .tms_out(tms), .tdi_out(tdi),
        .tdo_in(tdo));
    // expected captured chain, position 0 first out
    function automatic logic [26:0] chain(logic [9:0] c, logic [13:0] p,
                                          logic [1:0] e, logic a);
        return {p[13:8], c[9], ~a, c[8], p[7:3], c[7:6], ~e[1], c[5:4],
                p[2:0], c[3:2], ~e[0], c[1:0]};
    endfunction
    task results();
        if (err_count == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // hang guard
    always @(posedge clk_in)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            err_count++;
            results();
        end
    end
    initial
    begin
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'h1;
        u_tst.reset_tap();
        u_tst.scan(1'h0, 32, 32'h0, -1, q);
        `CHK(q, `JTB_ID_VALUE)
        `CHK(pv, cv)
        `CHK(tdo_oe, 1'h0)
        u_tst.scan(1'h1, 3, `JTB_IR_SAMPLE, -1, q);
        `CHK(q[2:0], `JTB_IR_CAPTURE)
        // sample: all-ones, then random pins and core values captured into the chain
        for (int k = 0; k < 4; k++)
        begin
            r = (k == 0) ? 32'h07ffffff : $random(seed);
            @(posedge clk_in);
            cv <= r[9:0];
            pin <= r[23:10];
            rx_en <= r[25:24];
            ack_en <= r[26];
            repeat (4) @(posedge tck);
            u_tst.scan(1'h0, 27, 32'h0, -1, q);
            `CHK(q[26:0], chain(cv, pin, rx_en, ack_en))
            `CHK(pv, cv)
            `CHK({ack_oe, rx_oe}, {ack_en, rx_en})
            `CHK(cp, pin)
        end
        // bypass: one stage of delay, captured zero first, paused midway
        u_tst.scan(1'h1, 3, `JTB_IR_BYPASS, -1, q);
        `CHK(q[2:0], `JTB_IR_CAPTURE)
        d = $random(seed);
        u_tst.scan(1'h0, 8, d, 3, q);
        `CHK(q[7:0], {d[6:0], 1'h0})
        u_tst.scan(1'h1, 3, `JTB_IR_EXTEST, 1, q);
        `CHK(q[2:0], `JTB_IR_CAPTURE)
        // extest: shifted chain drives pins and float controls
        for (int k = 0; k < 4; k++)
        begin
            d = (k == 0) ? 32'h07ffffff : $random(seed);
            u_tst.scan(1'h0, 27, d, k * 6 + 2, q);
            repeat (6) @(posedge clk_in);
            `CHK(pv, {d[20], d[18], d[12:11], d[9:8], d[4:3], d[1:0]})
            `CHK(rx_oe, {~d[10], ~d[2]})
            `CHK(ack_oe, ~d[19])
            `CHK(act, 1'h1)
        end
        u_tst.reset_tap();
        repeat (6) @(posedge clk_in);
        `CHK(act, 1'h0)
        results();
    end
endmodule
`default_nettype wire
